// >>> capture_pkg.sv
// constants and types for the waveform capture recorder
// Function
// - overwrite mode lets new records replace old
// - trigger position sets pre and post share
// - trigger operand always stored in each record
// - acquisition always 64 samples per power cycle
// - stored rate only thins stored samples
// - analog slots record selection, off slots skipped
// - all eight channels per module stored
// - channel labels: slot, terminal, kind, phase
// - no modules means digital traces only
// - record count change erases all records
// - analog value list built at startup
// - fixed pool shared among records
// - overlapping records captured concurrently
package capture_pkg;
  localparam int CLOCK_HZ = 10_000_000;
  localparam int LINE_HZ = 60;
  localparam int SAMPLES_PER_CYCLE = 64;
  localparam int ACQ_DIV = CLOCK_HZ / (LINE_HZ * SAMPLES_PER_CYCLE);
  localparam int STARTUP_CYCLES = 8;
  localparam int CH_PER_MOD = 8;
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] TRIGPOS_OFS = 8'h04;
  localparam logic [7:0] ANSEL_OFS = 8'h08;
  localparam logic [7:0] TRIGSEL_OFS = 8'h0c;
  localparam logic [7:0] STATUS_OFS = 8'h10;
  localparam logic [7:0] GEOM_OFS = 8'h14;
  localparam logic [7:0] LABEL_OFS = 8'h18;
  localparam logic [7:0] RDADDR_OFS = 8'h1c;
  localparam logic [7:0] RDDATA_OFS = 8'h20;
  localparam int CTRL_COUNT_LSB = 0;
  localparam int CTRL_OVERWRITE_BIT = 2;
  localparam int CTRL_RATE_LSB = 4;
  localparam logic [1:0] COUNT_RESET = 2'h0;
  localparam logic [1:0] RATE_RESET = 2'h0;
  localparam logic [6:0] TRIGPOS_RESET = 7'h32;
  localparam logic [6:0] PCT_MAX = 7'h64;
  localparam logic [15:0] ANSEL_RESET = 16'h0000;
  localparam logic [7:0] SLOT_FIRST = 8'h46;
  localparam logic [7:0] SLOT_SECOND = 8'h4c;
  localparam logic [1:0] PHASE_FOURTH = 2'h3;
  typedef enum logic [2:0] {
    W_IDLE = 3'b001,
    W_PRE = 3'b010,
    W_POST = 3'b100
  } wstate_t;
endpackage

// >>> rate_decimator.sv
// thins the acquisition tick down to the stored sample rate
module rate_decimator (
  input wire logic clock, // system clock
  input wire logic rst_n, // sync reset, active low
  input wire logic acqTick, // one per acquired sample
  input wire logic [1:0] rateSel, // 0:64 1:32 2:16 3:8 per cycle
  output logic storeTick // one per stored sample
);
  logic [2:0] cnt, next_cnt;
  logic [2:0] lim;
  always_comb begin
    lim = 3'((4'h1 << rateSel) - 4'h1);
    next_cnt = cnt;
    storeTick = 1'b0;
    if (acqTick) begin
      if (cnt >= lim) begin
        next_cnt = 3'h0;
        storeTick = 1'b1;
      end else begin
        next_cnt = cnt + 3'h1;
      end
    end
  end
  always_ff @(posedge clock) begin
    if (!rst_n) cnt <= 3'h0;
    else cnt <= next_cnt;
  end
endmodule

// >>> record_writer.sv
// one record writer: circular pre-trigger fill, then post count
module record_writer #(
  parameter int AW = 8
) (
  input wire logic clock, // system clock
  input wire logic rst_n, // sync reset, active low
  input wire logic clear, // drop any capture in progress
  input wire logic arm, // start filling record at base
  input wire logic trig, // trigger for this writer
  input wire logic wordEn, // a frame word is offered
  input wire logic [AW-1:0] base, // record start word
  input wire logic [AW:0] recWords, // record length in words
  input wire logic [AW:0] postWords, // words kept after trigger
  output logic [AW-1:0] wrAddr, // pool write address
  output logic wrEn, // pool write strobe
  output logic armed, // filling pre-trigger data
  output logic inPost, // filling post-trigger data
  output logic done // record closed, one cycle
);
  capture_pkg::wstate_t state, next_state;
  logic [AW-1:0] baseR, next_baseR;
  logic [AW:0] ofs, next_ofs, remain, next_remain, ofsInc;
  always_comb begin
    next_state = state;
    next_baseR = baseR;
    next_ofs = ofs;
    next_remain = remain;
    ofsInc = ofs + 1'b1;
    armed = (state == capture_pkg::W_PRE);
    inPost = (state == capture_pkg::W_POST);
    done = inPost && remain == '0;
    wrEn = wordEn && (armed || (inPost && remain != '0));
    wrAddr = AW'(baseR + ofs[AW-1:0]);
    if (wrEn) next_ofs = (ofsInc >= recWords) ? '0 : ofsInc;
    case (state)
      capture_pkg::W_IDLE: begin
        if (arm) begin
          next_state = capture_pkg::W_PRE;
          next_baseR = base;
          next_ofs = '0;
        end
      end
      capture_pkg::W_PRE: begin
        if (trig) begin
          next_state = capture_pkg::W_POST;
          next_remain = postWords;
        end
      end
      capture_pkg::W_POST: begin
        if (done) next_state = capture_pkg::W_IDLE;
        else if (wrEn) next_remain = remain - 1'b1;
      end
      default: next_state = capture_pkg::W_IDLE;
    endcase
    if (clear) next_state = capture_pkg::W_IDLE;
  end
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      state <= capture_pkg::W_IDLE;
      baseR <= '0;
      ofs <= '0;
      remain <= '0;
    end else begin
      state <= next_state;
      baseR <= next_baseR;
      ofs <= next_ofs;
      remain <= next_remain;
    end
  end
endmodule

// >>> waveform_capture_recorder.sv
// triggered waveform recorder with an apb register file
module waveform_capture_recorder #(
  parameter int POOL_WORDS = 256,
  parameter int MAX_CT = 2,
  parameter int NMETER = 8,
  parameter int CT_METERS = 2,
  parameter int AI_METERS = 2,
  parameter int NOPS = 16,
  parameter int ACQ_CYCLES = capture_pkg::ACQ_DIV
) (
  input wire logic clock, // 10 MHz system clock
  input wire logic rst_n, // sync reset, active low
  input wire logic psel, // apb select
  input wire logic penable, // apb access phase
  input wire logic pwrite, // apb direction
  input wire logic [7:0] paddr, // apb byte address
  input wire logic [31:0] pwdata, // apb write data
  output logic [31:0] prdata, // apb read data
  output logic pready, // apb ready
  output logic pslverr, // apb error, unmapped address
  input wire logic [MAX_CT*8*16-1:0] chanData, // module channels
  input wire logic [NMETER*16-1:0] meterVal, // metered values
  input wire logic [NOPS-1:0] operands, // digital operands
  input wire logic [1:0] ctModsPin, // fitted current/voltage mods
  input wire logic [1:0] aiModsPin, // fitted analog input mods
  output logic acqStrobe // acquisition sample strobe
);
  localparam int AW = $clog2(POOL_WORDS);
  localparam int NSLOT = 4;
  localparam int NPOS = MAX_CT * 8 + NSLOT + 1;
  localparam int PW = $clog2(NPOS + 1);
  localparam logic [PW-1:0] DIG_POS = PW'(NPOS - 1);
  localparam logic [PW-1:0] AN_POS = PW'(MAX_CT * 8);
  localparam logic [11:0] ACQ_LAST = 12'(ACQ_CYCLES - 1);

  // register file
  logic [1:0] countLog2, next_countLog2, rateSel, next_rateSel;
  logic overwrite, next_overwrite, clearAll, next_clearAll;
  logic [6:0] trigPct, next_trigPct;
  logic [15:0] anSel, next_anSel;
  logic [3:0] trigSel, next_trigSel, labelIdx, next_labelIdx;
  logic [AW-1:0] rdAddr, next_rdAddr;
  logic [31:0] next_prdata, readVal;
  logic next_pready, next_pslverr, hit, access, wrDone;

  // startup and acquisition
  logic [1:0] ctS1, ctS2, aiS1, aiS2;
  logic [1:0] ctMods, next_ctMods, aiMods, next_aiMods;
  logic [3:0] startCnt, next_startCnt, availMeters, next_availMeters;
  logic startupDone, next_startupDone;
  logic [11:0] acqDiv, next_acqDiv;
  logic acqTick, next_acqStrobe, storeTick;

  // frame sequencing and record bookkeeping
  logic [PW-1:0] seqPos, next_seqPos;
  logic seqActive, next_seqActive, wordEn;
  logic [15:0] wordData;
  logic [4:0] frameWords;
  logic [3:0] storedCount, next_storedCount, numRecs;
  logic [2:0] nextRec, next_nextRec;
  logic trigPrev, next_trigPrev, trigBit, trigEdge;
  logic [AW:0] recWords, preWords, postWords;
  logic [AW-1:0] armBase;
  logic [1:0] wArmed, wPost, wDone, wWrEn, wArm;
  logic [AW-1:0] wAddr [2];
  logic [1:0] activeCnt;
  logic [15:0] mem [POOL_WORDS];
  logic [15:0] next_mem [POOL_WORDS];
  logic [15:0] label;
  logic [2:0] chK;

  assign access = psel && penable;
  assign wrDone = access && pready && pwrite;

  // channel label: slot letter, terminal, current or voltage, phase
  always_comb begin
    chK = labelIdx[2:0];
    label = '0;
    label[7:0] = labelIdx[3] ? capture_pkg::SLOT_SECOND
                             : capture_pkg::SLOT_FIRST;
    label[11:8] = 4'(chK) + 4'h1;
    label[12] = chK[2];
    label[14:13] = chK[1:0];
  end

  always_comb begin
    hit = 1'b1;
    readVal = '0;
    if (paddr == capture_pkg::CTRL_OFS) begin
      readVal[capture_pkg::CTRL_COUNT_LSB +: 2] = countLog2;
      readVal[capture_pkg::CTRL_OVERWRITE_BIT] = overwrite;
      readVal[capture_pkg::CTRL_RATE_LSB +: 2] = rateSel;
    end else if (paddr == capture_pkg::TRIGPOS_OFS) begin
      readVal[6:0] = trigPct;
    end else if (paddr == capture_pkg::ANSEL_OFS) begin
      readVal[15:0] = anSel;
    end else if (paddr == capture_pkg::TRIGSEL_OFS) begin
      readVal[3:0] = trigSel;
    end else if (paddr == capture_pkg::STATUS_OFS) begin
      readVal[3:0] = storedCount;
      readVal[6:4] = nextRec;
      readVal[9:8] = wArmed;
      readVal[11:10] = wPost;
      readVal[13:12] = ctMods;
      readVal[15:14] = aiMods;
      readVal[16] = startupDone;
      readVal[23:20] = availMeters;
    end else if (paddr == capture_pkg::GEOM_OFS) begin
      readVal[AW:0] = recWords;
      readVal[20:16] = frameWords;
    end else if (paddr == capture_pkg::LABEL_OFS) begin
      readVal[3:0] = labelIdx;
      readVal[31:16] = label;
    end else if (paddr == capture_pkg::RDADDR_OFS) begin
      readVal[AW-1:0] = rdAddr;
    end else if (paddr == capture_pkg::RDDATA_OFS) begin
      readVal[15:0] = mem[rdAddr];
    end else begin
      hit = 1'b0;
    end
  end

  always_comb begin
    next_countLog2 = countLog2;
    next_overwrite = overwrite;
    next_rateSel = rateSel;
    next_trigPct = trigPct;
    next_anSel = anSel;
    next_trigSel = trigSel;
    next_labelIdx = labelIdx;
    next_rdAddr = rdAddr;
    next_clearAll = 1'b0;
    next_pready = access && !pready;
    next_prdata = prdata;
    next_pslverr = pslverr;
    if (access && !pready) begin
      next_prdata = pwrite ? '0 : readVal;
      next_pslverr = !hit;
    end
    if (wrDone && paddr == capture_pkg::CTRL_OFS) begin
      next_countLog2 = pwdata[capture_pkg::CTRL_COUNT_LSB +: 2];
      next_overwrite = pwdata[capture_pkg::CTRL_OVERWRITE_BIT];
      next_rateSel = pwdata[capture_pkg::CTRL_RATE_LSB +: 2];
      next_clearAll = next_countLog2 != countLog2;
    end else if (wrDone && paddr == capture_pkg::TRIGPOS_OFS) begin
      next_trigPct = (pwdata[6:0] > capture_pkg::PCT_MAX)
                     ? capture_pkg::PCT_MAX : pwdata[6:0];
    end else if (wrDone && paddr == capture_pkg::ANSEL_OFS) begin
      next_anSel = pwdata[15:0];
    end else if (wrDone && paddr == capture_pkg::TRIGSEL_OFS) begin
      next_trigSel = pwdata[3:0];
    end else if (wrDone && paddr == capture_pkg::LABEL_OFS) begin
      next_labelIdx = pwdata[3:0];
    end else if (wrDone && paddr == capture_pkg::RDADDR_OFS) begin
      next_rdAddr = pwdata[AW-1:0];
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      countLog2 <= capture_pkg::COUNT_RESET;
      overwrite <= 1'b0;
      rateSel <= capture_pkg::RATE_RESET;
      trigPct <= capture_pkg::TRIGPOS_RESET;
      anSel <= capture_pkg::ANSEL_RESET;
      trigSel <= '0;
      labelIdx <= '0;
      rdAddr <= '0;
      clearAll <= 1'b0;
      pready <= 1'b0;
      prdata <= '0;
      pslverr <= 1'b0;
    end else begin
      countLog2 <= next_countLog2;
      overwrite <= next_overwrite;
      rateSel <= next_rateSel;
      trigPct <= next_trigPct;
      anSel <= next_anSel;
      trigSel <= next_trigSel;
      labelIdx <= next_labelIdx;
      rdAddr <= next_rdAddr;
      clearAll <= next_clearAll;
      pready <= next_pready;
      prdata <= next_prdata;
      pslverr <= next_pslverr;
    end
  end

  // module straps are caught once after startup
  always_comb begin
    next_startCnt = startCnt;
    next_startupDone = startupDone;
    next_ctMods = ctMods;
    next_aiMods = aiMods;
    next_availMeters = availMeters;
    if (!startupDone) begin
      next_startCnt = startCnt + 4'h1;
      if (startCnt == 4'(capture_pkg::STARTUP_CYCLES)) begin
        next_startupDone = 1'b1;
        next_ctMods = ctS2;
        next_aiMods = aiS2;
        next_availMeters = 4'(ctS2 * CT_METERS + aiS2 * AI_METERS);
        if (next_availMeters > 4'(NMETER))
          next_availMeters = 4'(NMETER);
      end
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      ctS1 <= '0;
      ctS2 <= '0;
      aiS1 <= '0;
      aiS2 <= '0;
      startCnt <= '0;
      startupDone <= 1'b0;
      ctMods <= '0;
      aiMods <= '0;
      availMeters <= '0;
    end else begin
      ctS1 <= ctModsPin;
      ctS2 <= ctS1;
      aiS1 <= aiModsPin;
      aiS2 <= aiS1;
      startCnt <= next_startCnt;
      startupDone <= next_startupDone;
      ctMods <= next_ctMods;
      aiMods <= next_aiMods;
      availMeters <= next_availMeters;
    end
  end

  // acquisition runs at a fixed rate whatever is stored
  always_comb begin
    acqTick = acqDiv == ACQ_LAST;
    next_acqDiv = acqTick ? '0 : acqDiv + 12'h1;
    next_acqStrobe = acqTick;
  end

  rate_decimator u_decim (
    .clock(clock),
    .rst_n(rst_n),
    .acqTick(acqTick),
    .rateSel(rateSel),
    .storeTick(storeTick)
  );

  // frame: module channels, enabled analog slots, digital word
  always_comb begin
    wordEn = 1'b0;
    wordData = '0;
    frameWords = 5'(ctMods * capture_pkg::CH_PER_MOD) + 5'h1;
    for (int s = 0; s < NSLOT; s++) begin
      if (anSel[s*4 +: 4] != 4'h0 && anSel[s*4 +: 4] <= availMeters)
        frameWords = frameWords + 5'h1;
    end
    trigBit = operands[trigSel];
    if (seqActive) begin
      if (seqPos < PW'(ctMods * capture_pkg::CH_PER_MOD)) begin
        wordEn = 1'b1;
        wordData = chanData[seqPos*16 +: 16];
      end else if (seqPos >= AN_POS && seqPos < DIG_POS) begin
        for (int s = 0; s < NSLOT; s++) begin
          if (seqPos == AN_POS + PW'(s) && anSel[s*4 +: 4] != 4'h0
              && anSel[s*4 +: 4] <= availMeters) begin
            wordEn = 1'b1;
            wordData = meterVal[(anSel[s*4 +: 4] - 4'h1)*16 +: 16];
          end
        end
      end else if (seqPos == DIG_POS) begin
        wordEn = 1'b1;
        wordData = {trigBit, operands[14:0]};
      end
    end
    next_seqPos = seqPos;
    next_seqActive = seqActive;
    if (storeTick) begin
      next_seqPos = '0;
      next_seqActive = 1'b1;
    end else if (seqActive) begin
      next_seqPos = seqPos + 1'b1;
      next_seqActive = seqPos != DIG_POS;
    end
  end

  // records share one fixed pool
  always_comb begin
    numRecs = 4'h1 << countLog2;
    recWords = (AW+1)'(POOL_WORDS >> countLog2);
    preWords = (AW+1)'((32'(recWords) * 32'(trigPct)) / 32'd100);
    postWords = recWords - preWords;
    armBase = AW'(32'(nextRec) * 32'(recWords));
    activeCnt = 2'(wArmed[0] | wPost[0]) + 2'(wArmed[1] | wPost[1]);
    trigEdge = trigBit && !trigPrev && startupDone;
    next_trigPrev = trigBit;
    wArm = '0;
    next_storedCount = storedCount;
    next_nextRec = nextRec;
    if (wArmed == 2'b00 && wPost != 2'b11 && startupDone
        && 4'(activeCnt) < numRecs
        && (overwrite || storedCount + 4'(activeCnt) < numRecs)) begin
      wArm = wPost[0] ? 2'b10 : 2'b01;
      next_nextRec = 3'((4'(nextRec) + 4'h1) & (numRecs - 4'h1));
      if (storedCount + 4'(activeCnt) >= numRecs)
        next_storedCount = storedCount - 4'h1;
    end
    next_storedCount = next_storedCount + 4'(wDone[0]) + 4'(wDone[1]);
    if (clearAll) begin
      next_storedCount = '0;
      next_nextRec = '0;
      wArm = '0;
    end
  end

  for (genvar g = 0; g < 2; g++) begin : g_writer
    record_writer #(.AW(AW)) u_wr (
      .clock(clock),
      .rst_n(rst_n),
      .clear(clearAll),
      .arm(wArm[g]),
      .trig(trigEdge && wArmed[g]),
      .wordEn(wordEn),
      .base(armBase),
      .recWords(recWords),
      .postWords(postWords),
      .wrAddr(wAddr[g]),
      .wrEn(wWrEn[g]),
      .armed(wArmed[g]),
      .inPost(wPost[g]),
      .done(wDone[g])
    );
  end

  always_comb begin
    next_mem = mem;
    for (int i = 0; i < POOL_WORDS; i++) begin
      if (clearAll) next_mem[i] = '0;
    end
    for (int g = 0; g < 2; g++) begin
      if (wWrEn[g] && !clearAll) next_mem[wAddr[g]] = wordData;
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      acqDiv <= '0;
      acqStrobe <= 1'b0;
      seqPos <= '0;
      seqActive <= 1'b0;
      storedCount <= '0;
      nextRec <= '0;
      trigPrev <= 1'b0;
      for (int i = 0; i < POOL_WORDS; i++) mem[i] <= '0;
    end else begin
      acqDiv <= next_acqDiv;
      acqStrobe <= next_acqStrobe;
      seqPos <= next_seqPos;
      seqActive <= next_seqActive;
      storedCount <= next_storedCount;
      nextRec <= next_nextRec;
      trigPrev <= next_trigPrev;
      mem <= next_mem;
    end
  end

  chk_acq_period: assert property (@(posedge clock) disable iff (!rst_n)
    acqStrobe |-> $past(acqDiv) == ACQ_LAST)
    else $error("acquisition strobe off the fixed rate");
  chk_store_on_acq: assert property (@(posedge clock) disable iff (!rst_n)
    storeTick |-> acqTick ##1 (seqActive && seqPos == '0))
    else $error("stored sample not aligned to acquisition");
  chk_count_clears: assert property (@(posedge clock) disable iff (!rst_n)
    (wrDone && paddr == capture_pkg::CTRL_OFS
     && pwdata[1:0] != countLog2) |=> clearAll ##1 storedCount == 4'h0)
    else $error("record count change did not erase records");
  chk_trig_stored: assert property (@(posedge clock) disable iff (!rst_n)
    (wordEn && seqPos == DIG_POS) |-> wordData[15] == operands[trigSel])
    else $error("trigger operand missing from digital word");
  chk_off_skipped: assert property (@(posedge clock) disable iff (!rst_n)
    (seqActive && seqPos == AN_POS && anSel[3:0] == 4'h0) |-> !wordEn)
    else $error("off analog slot consumed storage");
  chk_all_channels: assert property (@(posedge clock) disable iff (!rst_n)
    (seqActive && seqPos < PW'(ctMods * 8)) |-> wordEn)
    else $error("module channel not stored");
  chk_digital_only: assert property (@(posedge clock) disable iff (!rst_n)
    (startupDone && ctMods == 2'h0 && aiMods == 2'h0 && wordEn)
    |-> seqPos == DIG_POS)
    else $error("analog trace stored with no modules fitted");
  chk_full_discard: assert property (@(posedge clock) disable iff (!rst_n)
    (!overwrite && storedCount >= numRecs && !clearAll) |-> wArm == 2'b00)
    else $error("record replaced while overwrite is off");
  chk_apb_ready: assert property (@(posedge clock) disable iff (!rst_n)
    (psel && penable && !pready) |=> pready ##1 !pready)
    else $error("apb ready not a single cycle after access");
endmodule

// >>> chan_source.sv
// measurement front end model: channel and meter samples
module chan_source #(
  parameter int NCH = 16,
  parameter int NMET = 8
) (
  input wire logic clock, // system clock
  input wire logic acqStrobe, // one per acquired sample
  output logic [NCH*16-1:0] chanData, // module channel samples
  output logic [NMET*16-1:0] meterVal // metered values
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [11:0] sampleNo = 12'h000;
  initial begin
    chanData = '0;
    meterVal = '0;
  end
  // new sample on every strobe, each channel distinct
  always @(posedge clock) begin
    if (acqStrobe === 1'b1) begin
      sampleNo <= sampleNo + 12'h001;
      for (int c = 0; c < NCH; c++) begin
        chanData[c*16+:16] <= {c[3:0], sampleNo};
      end
      for (int m = 0; m < NMET; m++) begin
        meterVal[m*16+:16] <= {m[3:0], ~sampleNo};
      end
    end
  end
endmodule

// >>> tb.sv
// self-checking bench for the waveform capture recorder
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int ACQ = 32;
  logic clock;
  logic rst_n;
  logic psel;
  logic penable;
  logic pwrite;
  logic [7:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [255:0] chanData;
  logic [127:0] meterVal;
  logic [15:0] operands;
  logic [1:0] ctModsPin;
  logic [1:0] aiModsPin;
  logic acqStrobe;
  logic [31:0] rd;
  logic err;
  int n_errors = 0;
  int n_compared = 0;
  int cycles = 0;

  waveform_capture_recorder #(.ACQ_CYCLES(ACQ)) dut_u (
    .clock(clock), .rst_n(rst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .chanData(chanData),
    .meterVal(meterVal), .operands(operands), .ctModsPin(ctModsPin),
    .aiModsPin(aiModsPin), .acqStrobe(acqStrobe)
  );
  chan_source src_u (
    .clock(clock), .acqStrobe(acqStrobe), .chanData(chanData),
    .meterVal(meterVal)
  );

  initial begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end

  task automatic stop_test();
    $display("compared %0d errors %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == 40000) begin
      n_errors++;
      stop_test();
    end
  end

  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask

  // one apb transfer, entered just after a rising edge
  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] d);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    do begin
      @(posedge clock);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clock);
  endtask

  // read status until a field matches, or is nonzero when nz
  task automatic poll(input logic [31:0] m, input logic [31:0] v,
                      input bit nz);
    int k;
    k = 0;
    do begin
      apb(1'b0, capture_pkg::STATUS_OFS, 32'h0);
      k++;
    end while ((nz ? (rd & m) === 32'h0 : (rd & m) !== v) && k < 400);
  endtask

  task automatic t_reset();
    apb(1'b0, capture_pkg::CTRL_OFS, 32'h0);
    chk("ctrl reset", 32'h0, rd);
    apb(1'b0, capture_pkg::TRIGPOS_OFS, 32'h0);
    chk("trigpos reset", 32'h32, rd);
    apb(1'b0, 8'h24, 32'h0);
    chk("unmapped err", 32'h1, {31'h0, err});
    apb(1'b1, capture_pkg::TRIGPOS_OFS, 32'h7f);
    apb(1'b0, capture_pkg::TRIGPOS_OFS, 32'h0);
    chk("trigpos clamp", 32'h64, rd);
  endtask

  task automatic t_startup();
    poll(32'h10000, 32'h10000, 1'b0);
    chk("mods fitted", 32'h6, (rd >> 12) & 32'hf);
    chk("meters avail", 32'h6, (rd >> 20) & 32'hf);
  endtask

  task automatic t_label();
    apb(1'b1, capture_pkg::LABEL_OFS, 32'h3);
    apb(1'b0, capture_pkg::LABEL_OFS, 32'h0);
    chk("label 3", 32'h6446, rd >> 16);
    apb(1'b1, capture_pkg::LABEL_OFS, 32'hc);
    apb(1'b0, capture_pkg::LABEL_OFS, 32'h0);
    chk("label 12", 32'h154c, rd >> 16);
  endtask

  task automatic t_geom();
    apb(1'b1, capture_pkg::ANSEL_OFS, 32'h0f01);
    apb(1'b0, capture_pkg::GEOM_OFS, 32'h0);
    chk("geom", 32'h00120100, rd);
  endtask

  task automatic t_capture();
    apb(1'b1, capture_pkg::TRIGSEL_OFS, 32'h5);
    apb(1'b1, capture_pkg::TRIGPOS_OFS, 32'h19);
    poll(32'h300, 32'h0, 1'b1);
    chk("armed", 32'h1, {31'h0, (rd & 32'h300) !== 32'h0});
    operands[5] <= 1'b1;
    poll(32'hf, 32'h1, 1'b0);
    chk("stored one", 32'h1, rd & 32'hf);
    operands[5] <= 1'b0;
    poll(32'hf00, 32'h0, 1'b0);
    chk("full no arm", 32'h0, rd & 32'h300);
    apb(1'b1, capture_pkg::CTRL_OFS, 32'h4);
    poll(32'h300, 32'h0, 1'b1);
    chk("overwrite arm", 32'h1, {31'h0, (rd & 32'h300) !== 32'h0});
    chk("oldest dropped", 32'h0, rd & 32'hf);
    apb(1'b1, capture_pkg::CTRL_OFS, 32'h0);
    operands[5] <= 1'b1;
    poll(32'hf, 32'h1, 1'b0);
    chk("replaced one", 32'h1, rd & 32'hf);
    operands[5] <= 1'b0;
  endtask

  task automatic t_erase();
    apb(1'b1, capture_pkg::CTRL_OFS, 32'h1);
    apb(1'b0, capture_pkg::STATUS_OFS, 32'h0);
    chk("erased", 32'h0, rd & 32'hf);
    apb(1'b0, capture_pkg::GEOM_OFS, 32'h0);
    chk("rec words", 32'h80, rd & 32'h1ff);
  endtask

  // strobe spacing, unaffected by the stored rate
  task automatic t_rate(input logic [1:0] r);
    int k;
    apb(1'b1, capture_pkg::CTRL_OFS, {26'h0, r, 4'h1});
    k = 0;
    while (acqStrobe !== 1'b1 && k < 100) begin
      @(posedge clock);
      k++;
    end
    @(posedge clock);
    k = 1;
    while (acqStrobe !== 1'b1 && k < 100) begin
      @(posedge clock);
      k++;
    end
    chk("acq gap", ACQ, k);
  endtask

  // second reset with no modules strapped
  task automatic t_no_mods();
    rst_n <= 1'b0;
    ctModsPin <= 2'h0;
    aiModsPin <= 2'h0;
    repeat (2) @(posedge clock);
    rst_n <= 1'b1;
    @(posedge clock);
    apb(1'b1, capture_pkg::ANSEL_OFS, 32'h1);
    poll(32'h10000, 32'h10000, 1'b0);
    chk("no mods", 32'h0, (rd >> 12) & 32'hf);
    chk("no meters", 32'h0, (rd >> 20) & 32'hf);
    repeat (2 * ACQ) @(posedge clock);
    apb(1'b0, capture_pkg::GEOM_OFS, 32'h0);
    chk("digital only", 32'h1, rd >> 16);
  endtask

  initial begin
    rst_n = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    operands = 16'h0000;
    ctModsPin = 2'h2;
    aiModsPin = 2'h1;
    repeat (4) @(posedge clock);
    rst_n <= 1'b1;
    @(posedge clock);
    t_reset();
    t_startup();
    t_label();
    t_geom();
    t_capture();
    t_erase();
    t_rate(2'h0);
    t_rate(2'h3);
    t_no_mods();
    stop_test();
  end
endmodule
